// ---- bench/dma_link_asserts.sv ----
// Purpose: protocol and completion checks on the link between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the interface signals
`timescale 1ns/1ps
`include "dma_consts.svh"
module dma_link_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // link signals
    input wire logic req,
    input wire logic we,
    input wire dma_pkg::addr_t addr,
    input wire dma_pkg::word_t wdata,
    input wire dma_pkg::word_t rdata,
    input wire logic ack,
    input wire dma_pkg::chmask_t sync_evt,
    input wire logic irq
);
    import dma_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // software pending clear or enable write strobe; irq may only fall shortly after one
    wire clr_w = ack && we && (addr == `REG_PCLR || addr == `REG_IEN);
    chk_ack_single: assert property (ack |=> !ack) else $error("ack held too long");
    chk_ack_has_req: assert property (ack |-> req && $past(req)) else $error("ack without request");
    chk_req_answer: assert property ($rose(req) |-> ##[1:20] ack) else $error("request not answered");
    chk_irq_holds: assert property ($fell(irq) |-> $past(clr_w) || $past(clr_w, 2) || $past(clr_w, 3))
        else $error("irq dropped without clear");
    chk_pend_width: assert property (ack && !we && addr == `REG_PEND |-> rdata[31:16] == 16'h0000)
        else $error("pending upper bits set");
    chk_unmapped_zero: assert property (ack && !we && addr[15:12] == 4'h0 |-> rdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_irq_disable: assert property (ack && we && addr == `REG_IEN && wdata[15:0] == 16'h0000
        |=> ##1 !irq) else $error("irq stays with enables off");
    chk_rdata_hold: assert property (ack |=> $stable(rdata)) else $error("read data not held");
endmodule : dma_link_asserts

// ---- bench/testbench.sv ----
// Purpose: ping-pong reload, completion pending bit and interrupt at both ends
// Assumes: rx events map to channel 3 after reset
// Notes: buffer addresses drawn from an lfsr
`timescale 1ns/1ps
`include "dma_consts.svh"
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
    import dma_pkg::*;
    logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, rx_elem = 0, tx_elem = 0;
    logic [11:0] paddr = 12'h000;
    word_t pwdata = 32'h0, prdata, q, da, db;
    word_t lf = 32'he5296fb7;
    logic pready, pslverr, irq, elem_strobe, done_strobe;
    logic [1:0] elem_ch;
    int error_cnt = 0, total_checks = 0, dn = 0, ne = 0, n0 = 0;
    dma_link_if lnk ();
    dma_chan_ctrl dma_chan_ctrl_i (.mclk(mclk), .srst(srst), .lnk(lnk), .elem_strobe(elem_strobe),
        .elem_ch(elem_ch), .done_strobe(done_strobe));
    dma_host_end dma_host_end_i (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_elem(rx_elem), .tx_elem(tx_elem), .irq(irq), .lnk(lnk));
    dma_link_asserts dma_link_asserts_i (.mclk(mclk), .srst(srst), .req(lnk.req), .we(lnk.we), .addr(lnk.addr),
        .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack), .sync_evt(lnk.sync_evt), .irq(lnk.irq));
    // 50 ns period
    always #25 mclk = ~mclk;
    // completions seen
    always @(posedge mclk) if (done_strobe === 1'b1) dn++;
    // elements seen; only channel 3 may run, channel 2 gets events only while halted
    always @(posedge mclk) begin
        if (elem_strobe === 1'b1) begin
            ne++;
            `CHK("elem ch", 2'h3, elem_ch)
        end
    end
    function automatic word_t nx(word_t s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // pending bit picked by the code field of the options word
    function automatic logic [15:0] pend_exp(word_t channel_options_word);
        return 16'h0001 << channel_options_word[15:12];
    endfunction : pend_exp
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // one apb transfer; idle edge after so psel is never reassigned in one step
    task automatic apb(input logic w, input logic [11:0] a, input word_t d, output word_t r);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin @(posedge mclk); end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    // device access through the host command registers
    task automatic cmd(input logic w, input addr_t a, input word_t d, output word_t r);
        apb(1'b1, `H_CMD_ADDR, {16'h0, a}, r);
        // reads preload junk so a missing read result cannot pass
        apb(1'b1, `H_CMD_DATA, w ? d : 32'hffff_ffff, r);
        apb(1'b1, `H_CMD_CTRL, {30'h0, w, 1'b1}, r);
        do begin apb(1'b0, `H_STATUS, 32'h0, r); end while (r[0] !== 1'b0);
        apb(1'b0, `H_CMD_DATA, 32'h0, r);
    endtask : cmd
    // one set: completion enabled, code 3, two arrays, one frame
    task automatic set_wr(input addr_t b, input logic [15:0] link, input word_t dst);
        word_t v[8];
        v = '{32'h0010_3000, 32'h0, 32'h0002_0001, dst, 32'h0001_0000, {16'h0002, link}, 32'h0, 32'h1};
        for (int i = 0; i < 8; i++) cmd(1'b1, b + 16'(i * 4), v[i], q);
    endtask : set_wr
    task automatic evt(input logic t = 1'b0);
        rx_elem <= 1'b1;
        tx_elem <= t;
        @(posedge mclk);
        rx_elem <= 1'b0;
        tx_elem <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : evt
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        lf = nx(lf); da = lf; lf = nx(lf); db = lf;
        set_wr(16'h4060, 16'h4800, da);
        set_wr(16'h4800, 16'h4820, db);
        set_wr(16'h4820, 16'h4800, da);
        cmd(1'b1, `REG_IEN, 32'h8, q);
        apb(1'b1, `H_INT_EN, 32'h2, q);
        cmd(1'b0, 16'h0020, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        for (int k = 0; k < 2; k++) begin
            evt();
            evt();
            cmd(1'b0, 16'h406c, 32'h0, q);
            `CHK("active dst", (k == 0) ? db : da, q)
            cmd(1'b0, `REG_PEND, 32'h0, q);
            `CHK("pending", pend_exp(32'h0010_3000), q[15:0])
            `CHK("done count", k + 1, dn)
            `CHK("irq", 1'b1, irq)
            `CHK("elems", 2 * (k + 1), ne)
            if (k == 1) begin
                // enables off while the pending bit is still set
                cmd(1'b1, `REG_IEN, 32'h0, q);
                apb(1'b0, `H_STATUS, 32'h0, q);
                `CHK("irq off", 1'b0, q[1])
            end
            cmd(1'b1, `REG_PCLR, 32'h8, q);
            apb(1'b1, `H_INT_CLR, 32'h2, q);
        end
        // halted channels drop events; channel 2 has no sets, so halt bit 2 stays set
        n0 = ne;
        cmd(1'b1, `REG_HALT, 32'hc, q);
        evt(1'b1);
        cmd(1'b0, `REG_HALT, 32'h0, q);
        `CHK("halt", 32'hc, q)
        `CHK("halted elems", n0, ne)
        cmd(1'b1, `REG_HALT, 32'h4, q);
        evt(1'b1);
        cmd(1'b0, `REG_PEND, 32'h0, q);
        `CHK("cleared", 16'h0000, q[15:0])
        `CHK("resumed elems", n0 + 1, ne)
        `CHK("host irq off", 1'b0, irq)
        `CHK("slverr", 1'b0, pslverr)
        end_sim();
    end
    // watchdog, far beyond the several hundred cycles needed
    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        end_sim();
    end
endmodule : testbench

// ---- common/dma_consts.svh ----
// Purpose: shared constants of the linked-reload channel controller and its host end
// Assumes: byte addresses on the link, 32-bit words
// Notes: offsets, field positions, reset values and counts only
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH

// ----------------------------------------------------------------
// device address map on the link
// ----------------------------------------------------------------
`define PRAM_BASE 16'h4000
`define PRAM_MASK 16'hf000
`define SET_ALIGN_MASK 16'h001f
`define REG_PEND 16'h1000
`define REG_PCLR 16'h1004
`define REG_IEN 16'h1008
`define REG_HALT 16'h100c

// ----------------------------------------------------------------
// parameter set layout (word index within a 0x20-byte set)
// ----------------------------------------------------------------
`define W_OPT 3'h0
`define W_CNT 3'h2
`define W_LNK 3'h5
`define W_CC 3'h7
`define W_LAST 3'h7
`define OPT_CIE_BIT 20
`define OPT_CODE_HI 15
`define OPT_CODE_LO 12
`define CNT_ONE 16'h0001

// ----------------------------------------------------------------
// device reset values
// ----------------------------------------------------------------
`define PEND_RST 16'h0000
`define IEN_RST 16'h0000
`define HALT_RST 4'h0

// ----------------------------------------------------------------
// host register map (apb byte offsets) and reset values
// ----------------------------------------------------------------
`define H_CMD_ADDR 12'h000
`define H_CMD_DATA 12'h004
`define H_CMD_CTRL 12'h008
`define H_STATUS 12'h00c
`define H_EVT_MAP 12'h010
`define H_INT_STAT 12'h014
`define H_INT_CLR 12'h018
`define H_INT_EN 12'h01c
`define CTRL_GO_BIT 0
`define CTRL_WE_BIT 1
`define INT_DONE_BIT 0
`define INT_DEVIRQ_BIT 1
`define EVT_MAP_RST 10'h203
`define HINT_RST 2'h0

`endif

// ---- common/dma_link_if.sv ----
// Purpose: link between the host end and the channel controller
// Assumes: both ends on mclk
// Notes: req held until a one-cycle ack; sync_evt one-cycle pulses
`timescale 1ns/1ps
interface dma_link_if;
    // register and parameter ram access
    logic req;
    logic we;
    dma_pkg::addr_t addr;
    dma_pkg::word_t wdata;
    dma_pkg::word_t rdata;
    logic ack;
    // per-channel sync events
    dma_pkg::chmask_t sync_evt;
    // completion interrupt
    logic irq;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        input sync_evt,
        output rdata,
        output ack,
        output irq
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        output sync_evt,
        input rdata,
        input ack,
        input irq
    );
endinterface : dma_link_if

// ---- common/dma_pkg.sv ----
// Purpose: types shared by both ends of the channel controller link
// Assumes: four channels, sixteen completion codes
// Notes: constants live in dma_consts.svh
package dma_pkg;

    typedef logic [15:0] addr_t;
    typedef logic [31:0] word_t;
    typedef logic [3:0] chmask_t;
    typedef logic [15:0] pend_t;

    // device sequencer, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CNT = 7'h02,
        ST_CC = 7'h04,
        ST_RLD = 7'h08,
        ST_FIN = 7'h10,
        ST_LNK = 7'h20,
        ST_COPY = 7'h40
    } dev_state_e;

    // host link master, one-hot
    typedef enum logic [1:0] {
        H_IDLE = 2'h1,
        H_REQ = 2'h2
    } host_state_e;

endpackage : dma_pkg

// ---- hdl/dma_chan_ctrl.sv ----
// Purpose: channel controller counting sync events, reloading linked sets, reporting completions
// Assumes: channel n runs from parameter set n; element datapath lies outside
// Notes: parameter ram and registers reached over dma_link_if
`timescale 1ns/1ps
`include "dma_consts.svh"
module dma_chan_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // link to host end
    dma_link_if.dev lnk,
    // element and completion reporting
    output logic elem_strobe,
    output logic [1:0] elem_ch,
    output logic done_strobe
);
    import dma_pkg::*;

    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    word_t mem [0:1023];
    dev_state_e state_r;
    dev_state_e state_nxt;
    logic [1:0] ch_r;
    logic [2:0] copy_i_r;
    logic [6:0] link_set_r;
    logic [15:0] acnt_r;
    pend_t pend_r;
    pend_t pend_nxt;
    pend_t pend_set;
    pend_t pend_clr;
    pend_t ien_r;
    chmask_t halt_r;
    chmask_t evt_q;
    chmask_t evt_clr;
    logic evt_any;
    logic [1:0] evt_sel;
    logic [9:0] rd_idx;
    logic [9:0] wr_idx;
    word_t rd_word;
    word_t wr_word;
    logic mem_we;
    logic bus_take;
    logic in_ram;
    logic link_ok;
    logic ack_r;
    word_t rdata_r;
    logic irq_r;
    logic elem_strobe_r;
    logic [1:0] elem_ch_r;
    logic done_strobe_r;

    // word index of word w in channel ch's active set
    function automatic logic [9:0] act_idx(input logic [1:0] ch, input logic [2:0] w);
        act_idx = {5'h00, ch, w};
    endfunction : act_idx

    // ----------------------------------------------------------------
    // event capture
    // ----------------------------------------------------------------
    // a halted channel drops its events, so a stale one cannot restart it
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_evt
            evt_latch u_evt (
                .mclk(mclk),
                .srst(srst),
                .set_pulse(lnk.sync_evt[gi] & ~halt_r[gi]),
                .clr_pulse(evt_clr[gi] | halt_r[gi]),
                .pend_q(evt_q[gi])
            );
        end
    endgenerate

    // lowest pending channel is served first
    always_comb begin
        evt_sel = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (evt_q[i]) begin
                evt_sel = i[1:0];
            end
        end
    end

    assign evt_any = |evt_q;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // bus only served while idle; ack_r blocks retaking a held request
    assign bus_take = (state_r == ST_IDLE) && lnk.req && !ack_r;
    assign in_ram = (lnk.addr & `PRAM_MASK) == `PRAM_BASE;
    // link must fall inside parameter ram on a set boundary, else no reload
    assign link_ok = ((rd_word[15:0] & `PRAM_MASK) == `PRAM_BASE)
                     && ((rd_word[15:0] & `SET_ALIGN_MASK) == 16'h0000);
    assign rd_word = mem[rd_idx];

    // ----------------------------------------------------------------
    // sequencer next state and ram port
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        rd_idx = lnk.addr[11:2];
        mem_we = 1'b0;
        wr_idx = lnk.addr[11:2];
        wr_word = lnk.wdata;
        pend_set = 16'h0000;
        evt_clr = 4'h0;
        case (state_r)
            ST_IDLE: begin
                if (bus_take) begin
                    mem_we = lnk.we && in_ram;
                end else if (evt_any) begin
                    evt_clr[evt_sel] = 1'b1;
                    state_nxt = ST_CNT;
                end
            end
            ST_CNT: begin
                // one array per event; the last one exhausts the frame
                rd_idx = act_idx(ch_r, `W_CNT);
                if (rd_word[31:16] > `CNT_ONE) begin
                    mem_we = 1'b1;
                    wr_idx = act_idx(ch_r, `W_CNT);
                    wr_word = {rd_word[31:16] - `CNT_ONE, rd_word[15:0]};
                    state_nxt = ST_IDLE;
                end else begin
                    state_nxt = ST_CC;
                end
            end
            ST_CC: begin
                rd_idx = act_idx(ch_r, `W_CC);
                if (rd_word[15:0] > `CNT_ONE) begin
                    mem_we = 1'b1;
                    wr_idx = act_idx(ch_r, `W_CC);
                    wr_word = {rd_word[31:16], rd_word[15:0] - `CNT_ONE};
                    state_nxt = ST_RLD;
                end else begin
                    state_nxt = ST_FIN;
                end
            end
            ST_RLD: begin
                // next frame: array count back from its reload half-word
                rd_idx = act_idx(ch_r, `W_LNK);
                mem_we = 1'b1;
                wr_idx = act_idx(ch_r, `W_CNT);
                wr_word = {rd_word[31:16], acnt_r};
                state_nxt = ST_IDLE;
            end
            ST_FIN: begin
                rd_idx = act_idx(ch_r, `W_OPT);
                if (rd_word[`OPT_CIE_BIT]) begin
                    pend_set[rd_word[`OPT_CODE_HI:`OPT_CODE_LO]] = 1'b1;
                end
                state_nxt = ST_LNK;
            end
            ST_LNK: begin
                rd_idx = act_idx(ch_r, `W_LNK);
                state_nxt = link_ok ? ST_COPY : ST_IDLE;
            end
            ST_COPY: begin
                // word-by-word copy; link word is read from the source set, not the target
                rd_idx = {link_set_r, copy_i_r};
                mem_we = 1'b1;
                wr_idx = act_idx(ch_r, copy_i_r);
                wr_word = rd_word;
                if (copy_i_r == `W_LAST) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer registers
    // ----------------------------------------------------------------
    // state
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // channel in service and saved low half of the count word
    always_ff @(posedge mclk) begin
        if (srst) begin
            ch_r <= 2'h0;
            acnt_r <= 16'h0000;
        end else begin
            if (state_r == ST_IDLE && !bus_take && evt_any) begin
                ch_r <= evt_sel;
            end
            if (state_r == ST_CNT) begin
                acnt_r <= rd_word[15:0];
            end
        end
    end

    // linked set number and copy position
    always_ff @(posedge mclk) begin
        if (srst) begin
            link_set_r <= 7'h00;
            copy_i_r <= 3'h0;
        end else begin
            if (state_r == ST_LNK) begin
                link_set_r <= rd_word[11:5];
                copy_i_r <= 3'h0;
            end else if (state_r == ST_COPY) begin
                copy_i_r <= copy_i_r + 3'h1;
            end
        end
    end

    // parameter ram write port
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[wr_idx] <= wr_word;
        end
    end

    // ----------------------------------------------------------------
    // registers on the link
    // ----------------------------------------------------------------
    assign pend_clr = (bus_take && lnk.we && lnk.addr == `REG_PCLR) ? lnk.wdata[15:0] : 16'h0000;
    // only software clears; a set in the same cycle wins
    assign pend_nxt = (pend_r & ~pend_clr) | pend_set;

    // pending flags
    always_ff @(posedge mclk) begin
        if (srst) begin
            pend_r <= `PEND_RST;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // interrupt enable and channel halt
    always_ff @(posedge mclk) begin
        if (srst) begin
            ien_r <= `IEN_RST;
            halt_r <= `HALT_RST;
        end else if (bus_take && lnk.we) begin
            if (lnk.addr == `REG_IEN) begin
                ien_r <= lnk.wdata[15:0];
            end
            if (lnk.addr == `REG_HALT) begin
                halt_r <= lnk.wdata[3:0];
            end
        end
    end

    // ack and read data; unmapped and write-only addresses read zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_take;
            if (bus_take && !lnk.we) begin
                if (in_ram) begin
                    rdata_r <= rd_word;
                end else if (lnk.addr == `REG_PEND) begin
                    rdata_r <= {16'h0000, pend_r};
                end else if (lnk.addr == `REG_IEN) begin
                    rdata_r <= {16'h0000, ien_r};
                end else if (lnk.addr == `REG_HALT) begin
                    rdata_r <= {28'h0000000, halt_r};
                end else begin
                    rdata_r <= 32'h0000_0000;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt and strobes
    // ----------------------------------------------------------------
    // level, one cycle behind the flags, so outputs stay registered
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(pend_r & ien_r);
        end
    end

    // element and completion pulses for the datapath
    always_ff @(posedge mclk) begin
        if (srst) begin
            elem_strobe_r <= 1'b0;
            elem_ch_r <= 2'h0;
            done_strobe_r <= 1'b0;
        end else begin
            elem_strobe_r <= (state_r == ST_CNT);
            elem_ch_r <= ch_r;
            done_strobe_r <= (state_r == ST_FIN);
        end
    end

    assign lnk.ack = ack_r;
    assign lnk.rdata = rdata_r;
    assign lnk.irq = irq_r;
    assign elem_strobe = elem_strobe_r;
    assign elem_ch = elem_ch_r;
    assign done_strobe = done_strobe_r;

endmodule : dma_chan_ctrl

// ---- hdl/dma_host_end.sv ----
// Purpose: apb-facing host end; forwards software accesses and serial-port events
// Assumes: serial port gives one-cycle element pulses
// Notes: one link command in flight at a time
`timescale 1ns/1ps
`include "dma_consts.svh"
module dma_host_end (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire dma_pkg::word_t pwdata,
    output dma_pkg::word_t prdata,
    output logic pready,
    output logic pslverr,
    // serial port events
    input wire logic rx_elem,
    input wire logic tx_elem,
    // interrupt to software
    output logic irq,
    // link to device
    dma_link_if.host lnk
);
    import dma_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    host_state_e state_r;
    addr_t cmd_addr_r;
    word_t cmd_data_r;
    logic req_r;
    logic we_r;
    logic [9:0] evt_map_r;
    logic [1:0] int_stat_r;
    logic [1:0] int_en_r;
    logic [1:0] int_set;
    logic [1:0] int_clr;
    logic dev_irq_d_r;
    chmask_t sync_r;
    word_t prdata_r;
    logic pready_r;
    logic irq_r;
    logic apb_wr;
    logic go;
    logic done;

    // write lands at the edge where pready is sampled high
    assign apb_wr = psel && penable && pready_r && pwrite;
    assign go = apb_wr && paddr == `H_CMD_CTRL && pwdata[`CTRL_GO_BIT] && state_r == H_IDLE;
    assign done = state_r == H_REQ && lnk.ack;

    // ----------------------------------------------------------------
    // apb slave: one wait cycle so read data comes from a flop
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= psel && penable && !pready_r;
            if (psel && penable && !pready_r) begin
                case (paddr)
                    `H_CMD_ADDR: prdata_r <= {16'h0000, cmd_addr_r};
                    `H_CMD_DATA: prdata_r <= cmd_data_r;
                    `H_STATUS: prdata_r <= {30'h0, lnk.irq, state_r == H_REQ};
                    `H_EVT_MAP: prdata_r <= {22'h0, evt_map_r};
                    `H_INT_STAT: prdata_r <= {30'h0, int_stat_r};
                    `H_INT_EN: prdata_r <= {30'h0, int_en_r};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // command registers; data is replaced by read results
    always_ff @(posedge mclk) begin
        if (srst) begin
            cmd_addr_r <= 16'h0000;
            cmd_data_r <= 32'h0000_0000;
            evt_map_r <= `EVT_MAP_RST;
        end else begin
            if (apb_wr && paddr == `H_CMD_ADDR && state_r == H_IDLE) begin
                cmd_addr_r <= pwdata[15:0];
            end
            if (apb_wr && paddr == `H_CMD_DATA && state_r == H_IDLE) begin
                cmd_data_r <= pwdata;
            end else if (done && !we_r) begin
                cmd_data_r <= lnk.rdata;
            end
            if (apb_wr && paddr == `H_EVT_MAP) begin
                evt_map_r <= pwdata[9:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // link master: request held until ack
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= H_IDLE;
            req_r <= 1'b0;
            we_r <= 1'b0;
        end else begin
            case (state_r)
                H_IDLE: begin
                    if (go) begin
                        req_r <= 1'b1;
                        we_r <= pwdata[`CTRL_WE_BIT]; // pending clears go out this way
                        state_r <= H_REQ;
                    end
                end
                H_REQ: begin
                    if (lnk.ack) begin
                        req_r <= 1'b0;
                        state_r <= H_IDLE;
                    end
                end
                default: begin
                    req_r <= 1'b0;
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    // serial-port element pulses steered to their channels
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync_r <= 4'h0;
        end else begin
            sync_r <= ({3'h0, rx_elem} << evt_map_r[1:0]) | ({3'h0, tx_elem} << evt_map_r[9:8]);
        end
    end

    // ----------------------------------------------------------------
    // host interrupt: command done, device interrupt rising
    // ----------------------------------------------------------------
    assign int_set = {lnk.irq && !dev_irq_d_r, done};
    assign int_clr = (apb_wr && paddr == `H_INT_CLR) ? pwdata[1:0] : 2'h0;

    // sticky status, set wins over clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            int_stat_r <= `HINT_RST;
            int_en_r <= `HINT_RST;
            dev_irq_d_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_set;
            if (apb_wr && paddr == `H_INT_EN) begin
                int_en_r <= pwdata[1:0];
            end
            dev_irq_d_r <= lnk.irq;
            irq_r <= |(int_stat_r & int_en_r);
        end
    end

    assign lnk.req = req_r;
    assign lnk.we = we_r;
    assign lnk.addr = cmd_addr_r;
    assign lnk.wdata = cmd_data_r;
    assign lnk.sync_evt = sync_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = 1'b0;
    assign irq = irq_r;

endmodule : dma_host_end

// ---- hdl/evt_latch.sv ----
// Purpose: holds one channel's sync event until the sequencer takes it
// Assumes: set and clear are one-cycle pulses
// Notes: set wins over clear so an event is never lost
`timescale 1ns/1ps
module evt_latch (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // control
    input wire logic set_pulse,
    input wire logic clr_pulse,
    // state
    output logic pend_q
);
    // sticky event flag
    always_ff @(posedge mclk) begin
        if (srst) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= set_pulse | (pend_q & ~clr_pulse);
        end
    end
endmodule : evt_latch
